// >>> rtl/dps_map.svh
// Purpose: register offsets, setting limits, reset values and timing counts of the protection supervisor
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
`define DPS_OFS_SEL 8'h00
`define DPS_OFS_LVL 8'h04
`define DPS_OFS_OVP 8'h08
`define DPS_OFS_OLC 8'h0C
`define DPS_OFS_OTQ 8'h10
`define DPS_OFS_FAN 8'h14
`define DPS_OFS_STAT 8'h18
`define DPS_SEL_RST 4'h0
`define DPS_LVL_RST 24'h96_9696
`define DPS_LVL_MIN 8'h32
`define DPS_LVL_MAX 8'hC8
`define DPS_OVP_RST 16'h0F3C
`define DPS_OVP_LO_MIN 16'h0DAC
`define DPS_OVP_LO_MAX 16'h0F3C
`define DPS_OVP_HI_MIN 16'h1B58
`define DPS_OVP_HI_MAX 16'h1E78
`define DPS_OTQ_THR_RST 9'h096
`define DPS_OTQ_THR_MIN 9'h01E
`define DPS_OTQ_THR_MAX 9'h12C
`define DPS_OTQ_DLY_RST 8'h00
`define DPS_OTQ_DLY_MAX 8'hFA
`define DPS_CT_CONT 8'h67
`define DPS_CT_ONEMIN 8'h96
`define DPS_VT_CONT 8'h71
`define DPS_VT_ONEMIN 8'h7B
`define DPS_MFO_OTQ 8'h0C
`define DPS_CLK_HZ 125000000
`define DPS_TICK_MS 100
`define DPS_TICK_CYC ((`DPS_CLK_HZ / 1000) * `DPS_TICK_MS)
`define DPS_OL_LIMIT 24'h00_2328
`define DPS_FAN_ON_C 8'h37
`define DPS_FAN_OFF_C 8'h32
`endif

// >>> rtl/dps_pkg.sv
// Purpose: types shared by the protection supervisor
// Assumes: nothing beyond the map header
// Notes: run state arrives from the output stage controller
package dps_pkg;
   typedef enum logic [1:0] {
      DPS_IDLE = 2'b00,
      DPS_ACCEL = 2'b01,
      DPS_DECEL = 2'b10,
      DPS_RUN = 2'b11
   } dps_phase_t;
   typedef struct packed {
      logic [7:0] current_pct;
      logic [8:0] torque_pct;
      logic [15:0] bus_dv;
      logic [7:0] speed_pct;
      logic [7:0] temp_c;
   } dps_meas_t;
   typedef struct packed {
      logic hold_ramp;
      logic force_decel;
      logic coast_stop;
   } dps_ctl_t;
endpackage : dps_pkg

// >>> rtl/dps_supervisor.sv
// Purpose: trip prevention, motor overload model, over-torque detection and fan control for a drive inverter
// Assumes: measurements arrive synchronous to clk; operator reset is a pin and is synchronised here
// Notes: registers over AXI4-Lite; bus voltage in tenths of a volt; times in 0.1 s ticks
`include "dps_map.svh"

// What this block does
// - four selection bits disable accel, decel, run stall and run overvoltage prevention.
// - accel, decel and run stall levels programmable fifty to two hundred percent.
// - run overvoltage level in tenths of a volt, low class range or doubled high class range.
// - accelerating with prevention on, hold ramp when current exceeds accel level.
// - decelerating with prevention on, hold ramp when bus voltage rises too high.
// - in run, excess torque forces deceleration until torque settles again.
// - overload enable setting zero turns the overload model on, one off.
// - motor type selects standard or inverter-duty overload model.
// - constant torque curve: unlimited below 103 percent, one minute at 150.
// - variable torque curve: continuous 113 percent, one minute at 123.
// - overload threshold drops at low speed on standard motors for reduced cooling.
// - overload action zero: coast, flash flag, wait for reset.
// - overload action one: keep running, flag clears at continuous level.
// - over-torque mode zero off, one at set frequency, two (or three) in every phase but idle.
// - over-torque declared after threshold exceeded continuously for the delay.
// - over-torque action zero: coast, flash flag, wait for reset.
// - over-torque action one: keep running, flag until torque below threshold.
// - multifunction output with code twelve follows the over-torque condition.
// - fan mode: temperature, while running, always on, always off.
module dps_supervisor
   import dps_pkg::*;
#(
   parameter int TICK_CYC = `DPS_TICK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // output stage
   input wire dps_phase_t phase,
   input wire logic at_set_freq,
   input wire dps_meas_t meas,
   input wire logic high_class,
   input wire logic fault_reset_pin,
   output dps_ctl_t ctl,
   // indications
   output logic motor_overload_flag,
   output logic overtorque_flag,
   output logic bus_overvoltage_indication,
   output logic heatsink_overheat,
   output logic mfo,
   output logic fan_on
);
   // configuration registers
   logic [3:0] sel;
   logic [7:0] lvl_acc, lvl_dec, lvl_run;
   logic [15:0] ovp_lvl;
   logic ol_off, ol_inv_motor, ol_vt, ol_act;
   logic [1:0] otq_mode;
   logic otq_act;
   logic [8:0] otq_thr;
   logic [7:0] otq_dly;
   logic [1:0] fan_mode;
   logic [7:0] mfo_func;
   // state
   logic [1:0] rst_sync;
   logic rst_sync_q;
   logic [31:0] tick_cnt;
   logic tick;
   logic [23:0] ol_acc;
   logic ol_trip_latched, otq_trip_latched;
   logic [7:0] otq_cnt;
   logic [3:0] blink_cnt;
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;

   // operator reset pin, synchronised and edge detected
   always_ff @(posedge clk) begin
      if (rst) begin
         rst_sync <= 2'b00;
         rst_sync_q <= 1'b0;
      end else begin
         rst_sync <= {rst_sync[0], fault_reset_pin};
         rst_sync_q <= rst_sync[1];
      end
   end
   wire fault_clear = rst_sync[1] & ~rst_sync_q;

   // 0.1 s tick for delays and the thermal model
   wire tick_wrap = (tick_cnt == TICK_CYC - 1);
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         tick_cnt <= tick_wrap ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
         tick <= tick_wrap;
      end
   end

   // trip prevention
   wire accel_on = (phase == DPS_ACCEL) & ~sel[0];
   wire decel_on = (phase == DPS_DECEL) & ~sel[1];
   wire run_stall_on = (phase == DPS_RUN) & ~sel[2];
   wire run_ovp_on = (phase == DPS_RUN) & ~sel[3];
   wire over_acc = meas.current_pct > lvl_acc;
   wire over_decv = meas.bus_dv > ovp_lvl;
   wire over_run_tq = meas.torque_pct > {1'b0, lvl_run};
   wire next_hold = (accel_on & over_acc)
      | (decel_on & (over_decv | meas.current_pct > lvl_dec))
      | (run_ovp_on & over_decv);
   wire next_force = run_stall_on & over_run_tq;

   // overload model: heat accumulates above the continuous level
   wire [7:0] cont_base = ol_vt ? `DPS_VT_CONT : `DPS_CT_CONT;
   wire [7:0] onemin_lvl = ol_vt ? `DPS_VT_ONEMIN : `DPS_CT_ONEMIN;
   // standard motors lose cooling below half speed; inverter-duty motors keep it
   wire low_speed = ~ol_inv_motor & (meas.speed_pct < 8'h32);
   wire [7:0] cont_lvl = low_speed ? (cont_base - (cont_base >> 2)) : cont_base;
   wire [7:0] excess = (meas.current_pct > cont_lvl) ? meas.current_pct - cont_lvl : 8'h00;
   wire [7:0] span = onemin_lvl - cont_base;
   // one minute at the one-minute level fills the limit: 600 ticks of 15 each when excess equals span
   wire [23:0] heat_step = ({16'h0000, excess} * 24'h00_000F) / {16'h0000, span};
   wire [23:0] limit = `DPS_OL_LIMIT;
   wire ol_over = ol_acc >= limit;
   always_ff @(posedge clk) begin
      if (rst | ol_off) begin
         ol_acc <= 24'h00_0000;
      end else if (tick) begin
         if (excess != 8'h00) begin
            ol_acc <= ol_over ? ol_acc : ol_acc + heat_step;
         end else begin
            ol_acc <= (ol_acc > 24'h00_000F) ? ol_acc - 24'h00_000F : 24'h00_0000;
         end
      end
   end
   wire ol_event = ~ol_off & ol_over;

   // over-torque detection
   wire otq_window = (otq_mode == 2'd2) ? (phase != DPS_IDLE)
      : (otq_mode == 2'd1) ? (at_set_freq & phase != DPS_IDLE) : 1'b0;
   wire otq_above = otq_window & (meas.torque_pct > otq_thr);
   wire otq_det = otq_above & (otq_cnt >= otq_dly);
   always_ff @(posedge clk) begin
      if (rst | ~otq_above) begin
         otq_cnt <= 8'h00;
      end else if (tick && otq_cnt != 8'hFF) begin
         otq_cnt <= otq_cnt + 8'h01;
      end
   end

   // latched trips; a new trip in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (rst) begin
         ol_trip_latched <= 1'b0;
         otq_trip_latched <= 1'b0;
      end else begin
         ol_trip_latched <= (ol_event & ~ol_act) | (ol_trip_latched & ~fault_clear);
         otq_trip_latched <= (otq_det & ~otq_act) | (otq_trip_latched & ~fault_clear);
      end
   end
   wire ol_show = ol_trip_latched | (ol_act & ol_event & meas.current_pct > cont_lvl);
   wire otq_show = otq_trip_latched | (otq_act & otq_det);

   // fan with hysteresis in auto mode
   logic next_fan;
   always_comb begin
      case (fan_mode)
         2'd0: next_fan = (meas.temp_c >= `DPS_FAN_ON_C) | (fan_on & meas.temp_c > `DPS_FAN_OFF_C);
         2'd1: next_fan = phase != DPS_IDLE;
         2'd2: next_fan = 1'b1;
         default: next_fan = 1'b0;
      endcase
   end

   // outputs registered; flags flash at about 0.8 s period
   always_ff @(posedge clk) begin
      if (rst) begin
         blink_cnt <= 4'h0;
         ctl <= '0;
         motor_overload_flag <= 1'b0;
         overtorque_flag <= 1'b0;
         bus_overvoltage_indication <= 1'b0;
         heatsink_overheat <= 1'b0;
         mfo <= 1'b0;
         fan_on <= 1'b0;
      end else begin
         if (tick) begin
            blink_cnt <= blink_cnt + 4'h1;
         end
         ctl.hold_ramp <= next_hold & ~ctl.coast_stop;
         ctl.force_decel <= next_force & ~ctl.coast_stop;
         ctl.coast_stop <= ol_trip_latched | otq_trip_latched;
         motor_overload_flag <= ol_show & blink_cnt[2];
         overtorque_flag <= otq_show & blink_cnt[2];
         bus_overvoltage_indication <= over_decv & (decel_on | run_ovp_on);
         heatsink_overheat <= meas.temp_c >= `DPS_FAN_ON_C;
         mfo <= (mfo_func == `DPS_MFO_OTQ) & (otq_det | otq_trip_latched);
         fan_on <= next_fan;
      end
   end

   // write channel: address and data taken in either order
   wire wr_go = aw_held & w_held & ~s_axi_bvalid;
   function automatic logic [7:0] clamp8(input logic [7:0] v);
      clamp8 = (v < `DPS_LVL_MIN) ? `DPS_LVL_MIN : (v > `DPS_LVL_MAX) ? `DPS_LVL_MAX : v;
   endfunction : clamp8
   wire [15:0] ovp_min = high_class ? `DPS_OVP_HI_MIN : `DPS_OVP_LO_MIN;
   wire [15:0] ovp_max = high_class ? `DPS_OVP_HI_MAX : `DPS_OVP_LO_MAX;
   wire [15:0] ovp_in = w_data[15:0];
   wire [15:0] ovp_clamped = (ovp_in < ovp_min) ? ovp_min : (ovp_in > ovp_max) ? ovp_max : ovp_in;
   wire [8:0] thr_in = w_data[8:0];
   wire [8:0] thr_clamped = (thr_in < `DPS_OTQ_THR_MIN) ? `DPS_OTQ_THR_MIN
      : (thr_in > `DPS_OTQ_THR_MAX) ? `DPS_OTQ_THR_MAX : thr_in;
   wire [7:0] dly_clamped = (w_data[23:16] > `DPS_OTQ_DLY_MAX) ? `DPS_OTQ_DLY_MAX : w_data[23:16];
   wire wr_ok = (aw_addr <= `DPS_OFS_STAT) & (aw_addr[1:0] == 2'b00);

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register stores; full words only, strobes must all be set
   wire wr_en = wr_go & (s_axi_wstrb == 4'hF);
   always_ff @(posedge clk) begin
      if (rst) begin
         sel <= `DPS_SEL_RST;
         {lvl_run, lvl_dec, lvl_acc} <= `DPS_LVL_RST;
         ovp_lvl <= `DPS_OVP_RST;
         {ol_act, ol_vt, ol_inv_motor, ol_off} <= 4'h0;
         {otq_act, otq_mode} <= 3'b000;
         otq_thr <= `DPS_OTQ_THR_RST;
         otq_dly <= `DPS_OTQ_DLY_RST;
         fan_mode <= 2'd0;
         mfo_func <= 8'h00;
      end else if (wr_en) begin
         case (aw_addr)
            `DPS_OFS_SEL: sel <= w_data[3:0];
            `DPS_OFS_LVL: begin
               lvl_acc <= clamp8(w_data[7:0]);
               lvl_dec <= clamp8(w_data[15:8]);
               lvl_run <= clamp8(w_data[23:16]);
            end
            `DPS_OFS_OVP: ovp_lvl <= ovp_clamped;
            `DPS_OFS_OLC: {ol_act, ol_vt, ol_inv_motor, ol_off} <= w_data[3:0];
            `DPS_OFS_OTQ: begin
               otq_mode <= (w_data[25:24] == 2'd3) ? 2'd2 : w_data[25:24];
               otq_act <= w_data[26];
               otq_thr <= thr_clamped;
               otq_dly <= dly_clamped;
            end
            `DPS_OFS_FAN: begin
               fan_mode <= w_data[1:0];
               mfo_func <= w_data[15:8];
            end
            default: begin
            end
         endcase
      end
   end

   // read channel
   logic [31:0] rd_word;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `DPS_OFS_SEL: rd_word = {28'h000_0000, sel};
         `DPS_OFS_LVL: rd_word = {8'h00, lvl_run, lvl_dec, lvl_acc};
         `DPS_OFS_OVP: rd_word = {16'h0000, ovp_lvl};
         `DPS_OFS_OLC: rd_word = {28'h000_0000, ol_act, ol_vt, ol_inv_motor, ol_off};
         `DPS_OFS_OTQ: rd_word = {5'h00, otq_act, otq_mode, otq_dly, 7'h00, otq_thr};
         `DPS_OFS_FAN: rd_word = {16'h0000, mfo_func, 6'h00, fan_mode};
         `DPS_OFS_STAT: rd_word = {ol_acc, ctl.coast_stop, fan_on, mfo, otq_show,
            ol_show, ctl.force_decel, ctl.hold_ramp, ol_trip_latched | otq_trip_latched};
         default: begin
            rd_word = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : dps_supervisor

// >>> test/dps_asserts.sv
// Purpose: port checks for the protection supervisor
// Assumes: bound to dps_supervisor
// Notes: settings are internal, so only port relations are checked
module dps_asserts
   import dps_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // output stage
   input wire dps_phase_t phase,
   input wire dps_meas_t meas,
   input wire logic fault_reset_pin,
   input wire dps_ctl_t ctl,
   input wire logic bus_overvoltage_indication,
   input wire logic heatsink_overheat,
   input wire logic mfo
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   hold_in_ramp_a: assert property (ctl.hold_ramp |-> $past(phase) inside {DPS_ACCEL, DPS_DECEL})
      else $error("hold outside a ramp");
   decel_in_run_a: assert property (ctl.force_decel |-> $past(phase) == DPS_RUN)
      else $error("forced decel outside run");
   // the pin passes two sync flops and an edge detector before it clears a trip
   coast_held_a: assert property ($fell(ctl.coast_stop) |-> $past(fault_reset_pin, 3) || $past(fault_reset_pin, 5))
      else $error("coast released without reset");
   mfo_in_run_a: assert property ($rose(mfo) |-> $past(phase) == DPS_RUN)
      else $error("mfo raised outside run");
   ovp_in_run_a: assert property (bus_overvoltage_indication |-> $past(phase) inside {DPS_DECEL, DPS_RUN})
      else $error("overvoltage shown outside decel or run");
   heat_level_a: assert property (!$past(rst) |-> heatsink_overheat == $past(meas.temp_c >= 8'h37))
      else $error("overheat level wrong");
   bresp_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rdata_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   coast_c: cover property ($rose(ctl.coast_stop));
   mfo_c: cover property ($rose(mfo));
   hold_c: cover property ($rose(ctl.hold_ramp));
endmodule : dps_asserts
bind dps_supervisor dps_asserts dps_asserts_inst (.clk(clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .phase(phase), .meas(meas),
   .fault_reset_pin(fault_reset_pin), .ctl(ctl), .bus_overvoltage_indication(bus_overvoltage_indication),
   .heatsink_overheat(heatsink_overheat), .mfo(mfo));

// >>> test/dps_stage_model.sv
// Purpose: output stage seen by the supervisor
// Assumes: bench commands phase and load
// Notes: registered, one cycle behind its commands
module dps_stage_model
   import dps_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire dps_phase_t cmd_phase,
   input wire dps_meas_t cmd_meas,
   input wire dps_ctl_t ctl,
   output dps_phase_t phase,
   output logic at_set_freq,
   output dps_meas_t meas
);
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= DPS_IDLE;
         at_set_freq <= 1'b0;
         meas <= '0;
      end else begin
         phase <= ctl.coast_stop ? DPS_IDLE : cmd_phase;
         at_set_freq <= cmd_phase == DPS_RUN && !ctl.force_decel && !ctl.hold_ramp;
         meas <= cmd_meas;
         // a coasting motor draws no current and makes no torque
         if (ctl.coast_stop) begin
            meas.current_pct <= 8'h00;
            meas.torque_pct <= 9'h000;
         end
      end
   end
endmodule : dps_stage_model

// >>> test/tb_drive_protection_supervisor.sv
// Purpose: self-checking bench for the protection supervisor
// Assumes: TICK_CYC of 10, so 0.1 s is 10 cycles
// Notes: random loads sit clear of the level under test
module tb_drive_protection_supervisor import dps_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, high_class = 1'b0, fault_reset_pin = 1'b0, at_set_freq, seen_ol, seen_cs;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cur;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   dps_phase_t cmd_phase = DPS_IDLE, phase;
   dps_meas_t cmd_meas = '0, meas;
   dps_ctl_t ctl;
   logic motor_overload_flag, overtorque_flag, bus_overvoltage_indication, heatsink_overheat, mfo, fan_on;
   int n_mismatch = 0, n_tests = 0;
   logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
   logic [31:0] rval [4] = '{32'h0000_0000, 32'h0096_9696, 32'h0000_0F3C, 32'h0000_0096};
   always #4 clk = ~clk;
   dps_stage_model dps_stage_model_inst (.clk(clk), .rst(rst), .cmd_phase(cmd_phase), .cmd_meas(cmd_meas),
      .ctl(ctl), .phase(phase), .at_set_freq(at_set_freq), .meas(meas));
   dps_supervisor #(.TICK_CYC(10)) dps_supervisor_inst (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .phase(phase),
      .at_set_freq(at_set_freq), .meas(meas), .high_class(high_class), .fault_reset_pin(fault_reset_pin),
      .ctl(ctl), .motor_overload_flag(motor_overload_flag), .overtorque_flag(overtorque_flag),
      .bus_overvoltage_indication(bus_overvoltage_indication), .heatsink_overheat(heatsink_overheat),
      .mfo(mfo), .fan_on(fan_on));
   function automatic logic prevent(input logic over, input logic off);
      return over && !off;
   endfunction : prevent
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // bready stands with the request; the answer is taken at the edge where bvalid is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask : rd
   task automatic set_in(input dps_phase_t p, input logic [7:0] c, input logic [8:0] tq, input logic [7:0] tc);
      @(posedge clk);
      cmd_phase <= p;
      cmd_meas <= '{current_pct: c, torque_pct: tq, bus_dv: 16'h0BB8, speed_pct: 8'h64, temp_c: tc};
   endtask : set_in
   task automatic watch(input int n);
      seen_ol = 1'b0;
      seen_cs = 1'b0;
      repeat (n) begin
         @(posedge clk);
         seen_ol |= motor_overload_flag === 1'b1;
         seen_cs |= ctl.coast_stop === 1'b1;
      end
   endtask : watch
   task automatic clear_fault();
      set_in(DPS_IDLE, 8'h00, 9'h000, 8'h1E);
      fault_reset_pin <= 1'b1;
      cyc(10);
      fault_reset_pin <= 1'b0;
      cyc(10);
   endtask : clear_fault
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      #320000;
      n_mismatch++;
      results();
   end
   initial begin
      void'($urandom(32590));
      cyc(3);
      rst <= 1'b0;
      foreach (ra[k]) begin
         rd(ra[k]);
         chk(rv, rval[k]);
      end
      rd(8'h1C);
      chk({rv, rsp}, 34'h0_0000_0002);
      wr(8'h04, 32'h0010_FF05);
      rd(8'h04);
      chk(rv, 32'h0032_C832);
      wr(8'h08, 32'h0000_0100);
      rd(8'h08);
      chk(rv, 32'h0000_0DAC);
      high_class <= 1'b1;
      wr(8'h08, 32'h0000_FFFF);
      rd(8'h08);
      chk(rv, 32'h0000_1E78);
      // levels are now 50 for accel and run
      for (int k = 0; k < 8; k++) begin
         wr(8'h00, k[0] ? 32'h0000_0005 : 32'h0000_0000);
         cur = k[1] ? 8'(51 + $urandom % 150) : 8'($urandom % 50);
         set_in(DPS_ACCEL, cur, 9'h000, 8'h1E);
         cyc(5);
         chk(ctl.hold_ramp, prevent(k[1], k[0]));
         set_in(DPS_RUN, 8'h00, {1'b0, cur}, 8'h1E);
         cyc(5);
         chk(ctl.force_decel, prevent(k[1], k[0]));
      end
      wr(8'h00, 32'h0000_000F);
      wr(8'h14, 32'h0000_0C02);
      for (int m = 0; m < 3; m++) begin
         wr(8'h10, 32'h0002_0064 | 32'(m << 24));
         set_in(DPS_RUN, 8'h00, 9'h0C8, 8'h1E);
         cyc(8);
         chk(ctl.coast_stop, 1'b0);
         cyc(30);
         chk(ctl.coast_stop, m != 0);
         set_in(DPS_RUN, 8'h00, 9'h000, 8'h1E);
         cyc(5);
         chk(ctl.coast_stop, m != 0);
         clear_fault();
         chk(ctl.coast_stop, 1'b0);
      end
      wr(8'h10, 32'h0602_0064);
      set_in(DPS_RUN, 8'h00, 9'h0C8, 8'h1E);
      cyc(38);
      chk({mfo, ctl.coast_stop}, 2'b10);
      set_in(DPS_RUN, 8'h00, 9'h032, 8'h1E);
      cyc(5);
      chk(mfo, 1'b0);
      for (int f = 0; f < 4; f++) begin
         wr(8'h14, 32'(f));
         cyc(5);
         chk(fan_on, f == 1 || f == 2);
      end
      wr(8'h00, 32'h0000_0000);
      @(posedge clk);
      cmd_phase <= DPS_DECEL;
      cmd_meas <= '{current_pct: 8'h00, torque_pct: 9'h000, bus_dv: 16'h2000, speed_pct: 8'h64, temp_c: 8'h1E};
      cyc(5);
      chk({ctl.hold_ramp, bus_overvoltage_indication}, 2'b11);
      wr(8'h00, 32'h0000_0002);
      cyc(5);
      chk({ctl.hold_ramp, bus_overvoltage_indication}, 2'b00);
      wr(8'h0C, 32'h0000_0000);
      set_in(DPS_RUN, 8'hC8, 9'h000, 8'h1E);
      watch(8000);
      chk({seen_cs, seen_ol}, 2'b11);
      clear_fault();
      wr(8'h0C, 32'h0000_0001);
      set_in(DPS_RUN, 8'hC8, 9'h000, 8'h1E);
      watch(8000);
      chk({seen_cs, seen_ol}, 2'b00);
      wr(8'h0C, 32'h0000_0008);
      watch(8000);
      chk({seen_cs, seen_ol}, 2'b01);
      set_in(DPS_RUN, 8'h32, 9'h000, 8'h1E);
      cyc(5);
      watch(20);
      chk(seen_ol, 1'b0);
      results();
   end
endmodule : tb_drive_protection_supervisor
